// [rtl/ebc_card.sv]
`timescale 1ns/1ps
module ebc_card #(
  parameter int RAM_KB = ebc_pkg::EBC_RAM_BASE_KB,
  parameter int ROM_KB = ebc_pkg::EBC_ROM_BASE_KB
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire ebc_pkg::ebc_host_req_t host_req_in,
  input wire ebc_pkg::ebc_pins_t pins_in,
  input wire logic [7:0] via_pa_drv_in,
  input wire logic [7:0] via_pb_drv_in,
  input wire logic [7:0] via_pb_dir_in,
  input wire logic via_pa_ctl_out_in,
  input wire logic via_pb_ctl_out_in,
  input wire logic via_irq_n_in,
  input wire logic ser_irq_n_in,
  input wire logic [7:0] per_pa_drv_in,
  input wire logic [7:0] per_pb_drv_in,
  input wire logic per_pa_ctl_out_in,
  input wire logic per_pb_ctl_out_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_rvalid_out,
  output logic bus_claim_out,
  output ebc_pkg::ebc_chip_sel_t chip_sel_out,
  output logic [15:0] rom_addr_out,
  output logic [16:0] ram_addr_out,
  output logic [7:0] via_pa_out,
  output logic [7:0] via_pb_out,
  output logic via_pa_ctl_in_out,
  output logic via_pb_ctl_in_out,
  output logic [7:0] per_pb_out,
  output logic [7:0] scsi_data_out,
  output logic scsi_data_oe_n_out,
  output logic [3:0] scsi_od_out,
  output logic [3:0] scsi_od_oe_n_out,
  output logic scsi_sel_n_out,
  output logic scsi_rst_n_out,
  output logic scsi_ack_n_out,
  output logic scsi_message_n_out,
  output logic prn_strobe_n_out,
  output logic rts_out,
  output logic dtr_out,
  output logic led_out
);
  import ebc_pkg::*;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Open-drain: pull low only when the port bit is an output holding 0
  function automatic logic od_oe_n(input logic dir, input logic drv);
    return !(dir && !drv);
  endfunction

  ebc_pins_t pins_s;
  logic [7:0] ctl_q;
  logic card_on;
  logic acc;
  logic hit_ser;
  logic hit_via;
  logic hit_per;
  logic hit_reg;
  logic hit_ram;
  logic hit_rom;
  logic rom_hi;
  logic ram_hi;
  logic [7:0] ram_bank;
  logic io_level;
  logic [7:0] status_w;
  ebc_stb_state_t stb_q;
  logic [4:0] stb_cnt_q;
  logic [4:0] low_len_q;

  ebc_sync #(
    .W($bits(ebc_pins_t)),
    .RST(EBC_PINS_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(pins_in),
    .q_out(pins_s)
  );

  assign acc = host_req_in.rd || host_req_in.wr;
  assign card_on = (ctl_q[3:0] != EBC_BANK_NONE);
  assign hit_ser = in_rng(host_req_in.addr, EBC_SER_LO, EBC_SER_HI);
  assign hit_via = in_rng(host_req_in.addr, EBC_VIA_LO, EBC_VIA_HI);
  assign hit_per = in_rng(host_req_in.addr, EBC_PER_LO, EBC_PER_HI);
  assign hit_reg = in_rng(host_req_in.addr, EBC_REG_LO, EBC_IO_HI);
  assign hit_ram = in_rng(host_req_in.addr, EBC_RAM_LO, EBC_RAM_HI) && card_on;
  assign hit_rom = in_rng(host_req_in.addr, EBC_ROM_LO, EBC_ROM_HI) && card_on;

  // Each top bank bit only exists on the largest build of its ROM or RAM; RAM bank bits 7:6 exist from the 32 KB build up
  assign rom_hi = (ROM_KB == EBC_ROM_BIG_KB) ? per_pb_drv_in[EBC_PER_ROMHI] : 1'b0;
  assign ram_hi = (RAM_KB == EBC_RAM_BIG_KB) ? per_pb_drv_in[EBC_PER_RAMHI] : 1'b0;
  assign ram_bank[5:0] = per_pa_drv_in[5:0];
  assign ram_bank[7:6] = (RAM_KB >= EBC_RAM_MID_KB) ? per_pa_drv_in[7:6] : 2'b00;

  assign io_level = via_pb_dir_in[EBC_PB_IO] ? via_pb_drv_in[EBC_PB_IO] : pins_s.io_n;

  always_comb begin
    status_w = 8'h00;
    status_w[EBC_ST_MENU] = pins_s.menu_n;
    status_w[EBC_ST_SHOT] = pins_s.shot_n;
    status_w[EBC_ST_VIA] = !via_irq_n_in;
    status_w[EBC_ST_SER] = !ser_irq_n_in;
    status_w[EBC_ST_DSR] = pins_s.dsr;
    status_w[EBC_ST_CTS] = pins_s.cts;
    status_w[EBC_ST_DCD] = pins_s.dcd;
  end

  // Control register is write-only; reads of the same range see status
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl_q <= EBC_CTL_RESET;
    end else if (host_req_in.wr && hit_reg) begin
      ctl_q <= host_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= 8'h00;
      bus_rvalid_out <= 1'b0;
      bus_claim_out <= 1'b0;
    end else begin
      bus_rvalid_out <= host_req_in.rd && hit_reg;
      bus_rdata_out <= (host_req_in.rd && hit_reg) ? status_w : 8'h00;
      bus_claim_out <= acc && (hit_ser || hit_via || hit_per || hit_reg || hit_ram
                               || hit_rom);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      chip_sel_out <= '0;
      rom_addr_out <= 16'h0000;
      ram_addr_out <= 17'h00000;
    end else begin
      chip_sel_out.ser <= acc && hit_ser;
      chip_sel_out.via <= acc && hit_via;
      chip_sel_out.per <= acc && hit_per;
      chip_sel_out.ram <= acc && hit_ram;
      chip_sel_out.rom <= acc && host_req_in.rd && hit_rom;
      chip_sel_out.rd <= host_req_in.rd;
      chip_sel_out.wr <= host_req_in.wr;
      // Low address lines go straight through, no swap of the middle pair
      chip_sel_out.rs <= host_req_in.addr[3:0];
      rom_addr_out <= {rom_hi, ctl_q[3:0], host_req_in.addr[10:0]};
      ram_addr_out <= {ram_hi, ram_bank, host_req_in.addr[7:0]};
    end
  end

  // Interface adapter side of the SCSI and printer buses
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      via_pa_out <= 8'h00;
      via_pb_out <= 8'hff;
      via_pa_ctl_in_out <= 1'b1;
      via_pb_ctl_in_out <= 1'b1;
      scsi_data_out <= 8'h00;
      scsi_data_oe_n_out <= 1'b1;
    end else begin
      via_pa_out <= ~pins_s.data;
      via_pb_out[EBC_PB_IO] <= pins_s.io_n;
      via_pb_out[EBC_PB_CD] <= pins_s.cd_n;
      via_pb_out[EBC_PB_SEL] <= via_pb_drv_in[EBC_PB_SEL];
      via_pb_out[EBC_PB_RST] <= via_pb_drv_in[EBC_PB_RST];
      via_pb_out[EBC_PB_BUSY] <= pins_s.busy;
      // Switch one on means no fault, and it cannot be read by itself
      via_pb_out[EBC_PB_FAULT] <= pins_s.fault_n || !pins_s.dip_n[0];
      via_pb_out[EBC_PB_BSY] <= pins_s.bsy_n;
      via_pb_out[EBC_PB_REQ] <= pins_s.req_n;
      via_pa_ctl_in_out <= pins_s.req_n;
      via_pb_ctl_in_out <= pins_s.menu_n && pins_s.shot_n;
      scsi_data_out <= ~via_pa_drv_in;
      scsi_data_oe_n_out <= !io_level;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scsi_od_out <= 4'h0;
      scsi_od_oe_n_out <= 4'hf;
      scsi_sel_n_out <= 1'b1;
      scsi_rst_n_out <= 1'b1;
      scsi_ack_n_out <= 1'b1;
      scsi_message_n_out <= 1'b1;
    end else begin
      scsi_od_out <= 4'h0;
      scsi_od_oe_n_out[0] <= od_oe_n(via_pb_dir_in[EBC_PB_IO], via_pb_drv_in[EBC_PB_IO]);
      scsi_od_oe_n_out[1] <= od_oe_n(via_pb_dir_in[EBC_PB_CD], via_pb_drv_in[EBC_PB_CD]);
      scsi_od_oe_n_out[2] <= od_oe_n(via_pb_dir_in[EBC_PB_BSY], via_pb_drv_in[EBC_PB_BSY]);
      scsi_od_oe_n_out[3] <= od_oe_n(via_pb_dir_in[EBC_PB_REQ], via_pb_drv_in[EBC_PB_REQ]);
      scsi_sel_n_out <= !via_pb_dir_in[EBC_PB_SEL] || via_pb_drv_in[EBC_PB_SEL];
      scsi_rst_n_out <= !via_pb_dir_in[EBC_PB_RST] || via_pb_drv_in[EBC_PB_RST];
      scsi_ack_n_out <= via_pa_ctl_out_in;
      scsi_message_n_out <= ctl_q[EBC_CTL_MESSAGE];
    end
  end

  // Peripheral adapter: switches in, modem controls and light out
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      per_pb_out <= 8'hff;
      rts_out <= 1'b0;
      dtr_out <= 1'b0;
      led_out <= 1'b0;
    end else begin
      per_pb_out <= {pins_s.dip_n[6:1], pins_s.wp_n, pins_s.mode_n};
      rts_out <= per_pa_ctl_out_in;
      dtr_out <= per_pb_ctl_out_in;
      led_out <= card_on;
    end
  end

  // Stretch the strobe: a too-short adapter pulse could be missed by slow printers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stb_q <= EBC_STB_IDLE;
      stb_cnt_q <= 5'd0;
      prn_strobe_n_out <= 1'b1;
    end else begin
      case (stb_q)
        EBC_STB_IDLE: begin
          if (!via_pb_ctl_out_in) begin
            stb_q <= EBC_STB_LOW;
            stb_cnt_q <= 5'(EBC_STB_CYC - 1);
            prn_strobe_n_out <= 1'b0;
          end
        end
        EBC_STB_LOW: begin
          if (stb_cnt_q != 5'd0) begin
            stb_cnt_q <= stb_cnt_q - 5'd1;
          end else if (via_pb_ctl_out_in) begin
            stb_q <= EBC_STB_IDLE;
            prn_strobe_n_out <= 1'b1;
          end
        end
        default: begin
          stb_q <= EBC_STB_IDLE;
          prn_strobe_n_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || prn_strobe_n_out) begin
      low_len_q <= 5'd0;
    end else if (low_len_q != 5'h1f) begin
      low_len_q <= low_len_q + 5'd1;
    end
  end

  property p_low_page;
    @(posedge clk_in) disable iff (!rst_n_in)
      (acc && in_rng(host_req_in.addr, EBC_IO_LO, EBC_UNUSED_HI)) |=> !bus_claim_out;
  endproperty
  a_low_page: assert property (p_low_page) else $error("unused page claimed");

  property p_ctl_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.wr && hit_reg) |=> ##1 (led_out == ($past(host_req_in.wdata, 2) != 8'h00)
                                           || $past(host_req_in.wdata, 2) > 8'h0f);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  property p_stat_read;
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_req_in.rd && hit_reg) |=> (bus_rvalid_out && bus_rdata_out == $past(status_w));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_led;
    @(posedge clk_in) disable iff (!rst_n_in)
      ##1 (led_out == ($past(ctl_q[3:0]) != EBC_BANK_NONE));
  endproperty
  a_led: assert property (p_led) else $error("light not following bank");

  property p_rom_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      (ctl_q[3:0] == EBC_BANK_NONE) |=> !chip_sel_out.rom && !chip_sel_out.ram;
  endproperty
  a_rom_off: assert property (p_rom_off) else $error("window mapped with no bank");

  property p_fault;
    @(posedge clk_in) disable iff (!rst_n_in)
      !pins_s.dip_n[0] |=> via_pb_out[EBC_PB_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not overridden");

  property p_strobe;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!prn_strobe_n_out && low_len_q < 5'(EBC_STB_CYC - 1)) |=> !prn_strobe_n_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too short");

  property p_dir;
    @(posedge clk_in) disable iff (!rst_n_in)
      io_level |=> (!scsi_data_oe_n_out && scsi_data_out == ~$past(via_pa_drv_in));
  endproperty
  a_dir: assert property (p_dir) else $error("data not driven outward");

  property p_buttons;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!pins_s.menu_n || !pins_s.shot_n) |=> !via_pb_ctl_in_out;
  endproperty
  a_buttons: assert property (p_buttons) else $error("button line not low");

  property p_ack;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(via_pa_ctl_out_in) |=> !scsi_ack_n_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not passed");
endmodule // ebc_card

// [rtl/ebc_pkg.sv]
package ebc_pkg;
  // Host address map of the card
  localparam logic [15:0] EBC_IO_LO = 16'hd100;
  localparam logic [15:0] EBC_UNUSED_HI = 16'hd11f;
  localparam logic [15:0] EBC_SER_LO = 16'hd120;
  localparam logic [15:0] EBC_SER_HI = 16'hd13f;
  localparam logic [15:0] EBC_VIA_LO = 16'hd150;
  localparam logic [15:0] EBC_VIA_HI = 16'hd17f;
  localparam logic [15:0] EBC_PER_LO = 16'hd180;
  localparam logic [15:0] EBC_PER_HI = 16'hd1bf;
  localparam logic [15:0] EBC_REG_LO = 16'hd1c0;
  localparam logic [15:0] EBC_IO_HI = 16'hd1ff;
  localparam logic [15:0] EBC_RAM_LO = 16'hd600;
  localparam logic [15:0] EBC_RAM_HI = 16'hd6ff;
  localparam logic [15:0] EBC_ROM_LO = 16'hd800;
  localparam logic [15:0] EBC_ROM_HI = 16'hdfff;

  // card_control fields
  localparam logic [7:0] EBC_CTL_RESET = 8'h00;
  localparam int EBC_CTL_MESSAGE = 4;
  localparam logic [3:0] EBC_BANK_NONE = 4'h0;

  // card_irq_status fields
  localparam int EBC_ST_SER = 0;
  localparam int EBC_ST_VIA = 1;
  localparam int EBC_ST_SHOT = 2;
  localparam int EBC_ST_MENU = 3;
  localparam int EBC_ST_DSR = 5;
  localparam int EBC_ST_CTS = 6;
  localparam int EBC_ST_DCD = 7;

  // Interface adapter port B lines
  localparam int EBC_PB_IO = 0;
  localparam int EBC_PB_CD = 1;
  localparam int EBC_PB_SEL = 2;
  localparam int EBC_PB_RST = 3;
  localparam int EBC_PB_BUSY = 4;
  localparam int EBC_PB_FAULT = 5;
  localparam int EBC_PB_BSY = 6;
  localparam int EBC_PB_REQ = 7;

  // Peripheral adapter port B bank bits
  localparam int EBC_PER_RAMHI = 1;
  localparam int EBC_PER_ROMHI = 2;

  // Build sizes in kilobytes
  localparam int EBC_RAM_BASE_KB = 8;
  localparam int EBC_RAM_MID_KB = 32;
  localparam int EBC_RAM_BIG_KB = 64;
  localparam int EBC_ROM_BASE_KB = 16;
  localparam int EBC_ROM_BIG_KB = 32;

  // Printer strobe least low time
  localparam int EBC_CLK_PS = 20000;
  localparam int EBC_STB_MIN_PS = 500000;
  localparam int EBC_STB_CYC = (EBC_STB_MIN_PS + EBC_CLK_PS - 1) / EBC_CLK_PS;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } ebc_host_req_t;

  typedef struct packed {
    logic ser;
    logic via;
    logic per;
    logic ram;
    logic rom;
    logic rd;
    logic wr;
    logic [3:0] rs;
  } ebc_chip_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic req_n;
    logic bsy_n;
    logic cd_n;
    logic io_n;
    logic busy;
    logic fault_n;
    logic [6:0] dip_n;
    logic mode_n;
    logic wp_n;
    logic menu_n;
    logic shot_n;
    logic dcd;
    logic cts;
    logic dsr;
  } ebc_pins_t;

  localparam ebc_pins_t EBC_PINS_IDLE = 28'hfff_fff8;

  typedef enum logic [1:0] {
    EBC_STB_IDLE = 2'b01,
    EBC_STB_LOW = 2'b10
  } ebc_stb_state_t;
endpackage

// [rtl/ebc_sync.sv]
`timescale 1ns/1ps
module ebc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only when the last two stages agree, so a glitch is dropped
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        q_out[i] <= RST[i];
      end else if (s2_q[i] == s3_q[i]) begin
        q_out[i] <= s3_q[i];
      end
    end
  end
endmodule // ebc_sync

// [tb/ebc_far_model.sv]
`timescale 1ns/1ps
module ebc_far_model (
  input wire logic clk_in,
  input wire ebc_pkg::ebc_pins_t env_in,
  input wire logic tgt_req_in,
  input wire logic [7:0] scsi_data_in,
  input wire logic scsi_data_oe_n_in,
  input wire logic [3:0] scsi_od_in,
  input wire logic [3:0] scsi_od_oe_n_in,
  input wire logic scsi_ack_n_in,
  output ebc_pkg::ebc_pins_t pins_out
);
  import ebc_pkg::*;
  logic req_q = 1'b0;
  logic [3:0] od_lvl;
  // Target holds its request until the card acknowledges it
  always_ff @(posedge clk_in) begin
    if (!scsi_ack_n_in) begin
      req_q <= 1'b0;
    end else if (tgt_req_in) begin
      req_q <= 1'b1;
    end
  end
  // Open-drain lines are pulled up; any party pulling low wins
  assign od_lvl = {!req_q, env_in.bsy_n, env_in.cd_n, env_in.io_n}
    & (scsi_od_oe_n_in | scsi_od_in);
  always_comb begin
    pins_out = env_in;
    pins_out.data = scsi_data_oe_n_in ? env_in.data : scsi_data_in;
    {pins_out.req_n, pins_out.bsy_n, pins_out.cd_n, pins_out.io_n} = od_lvl;
  end
endmodule // ebc_far_model

// [tb/expansion_io_card_glue_tb.sv]
`timescale 1ns/1ps
module expansion_io_card_glue_tb;
  import ebc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ebc_host_req_t hreq = '0;
  ebc_pins_t env = EBC_PINS_IDLE;
  ebc_pins_t pins;
  ebc_chip_sel_t cs;
  logic [7:0] vpa = 8'h00, vpb = 8'h00, vdir = 8'h00, ppa = 8'h00, ppb = 8'h00;
  logic ack_ctl = 1'b1, stb_ctl = 1'b1, virq_n = 1'b1, airq_n = 1'b1;
  logic rts_ctl = 1'b0, dtr_ctl = 1'b0, treq = 1'b0;
  logic [7:0] rdata, vpa_o, vpb_o, ppb_o, sd;
  logic rvalid, claim, req_ctl, btn_ctl, sd_oe_n, sel_n, rst_n, ack_n, msg_n, stb_n, rts, dtr;
  logic led;
  logic [15:0] rom_a, rom_a_big;
  logic [16:0] ram_a, ram_a_big;
  logic [3:0] od, od_oe_n;
  int num_errors = 0;
  int cmp_count = 0;

  always #10 clk_in = ~clk_in;

  ebc_card dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_req_in(hreq), .pins_in(pins),
    .via_pa_drv_in(vpa), .via_pb_drv_in(vpb), .via_pb_dir_in(vdir),
    .via_pa_ctl_out_in(ack_ctl), .via_pb_ctl_out_in(stb_ctl), .via_irq_n_in(virq_n),
    .ser_irq_n_in(airq_n), .per_pa_drv_in(ppa), .per_pb_drv_in(ppb),
    .per_pa_ctl_out_in(rts_ctl), .per_pb_ctl_out_in(dtr_ctl), .bus_rdata_out(rdata),
    .bus_rvalid_out(rvalid), .bus_claim_out(claim), .chip_sel_out(cs), .rom_addr_out(rom_a),
    .ram_addr_out(ram_a), .via_pa_out(vpa_o), .via_pb_out(vpb_o),
    .via_pa_ctl_in_out(req_ctl), .via_pb_ctl_in_out(btn_ctl), .per_pb_out(ppb_o),
    .scsi_data_out(sd), .scsi_data_oe_n_out(sd_oe_n), .scsi_od_out(od),
    .scsi_od_oe_n_out(od_oe_n), .scsi_sel_n_out(sel_n), .scsi_rst_n_out(rst_n),
    .scsi_ack_n_out(ack_n), .scsi_message_n_out(msg_n), .prn_strobe_n_out(stb_n),
    .rts_out(rts), .dtr_out(dtr), .led_out(led));

  ebc_card #(.RAM_KB(EBC_RAM_BIG_KB), .ROM_KB(EBC_ROM_BIG_KB)) dut_big (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .host_req_in(hreq), .pins_in(pins), .via_pa_drv_in(vpa),
    .via_pb_drv_in(vpb), .via_pb_dir_in(vdir), .via_pa_ctl_out_in(ack_ctl),
    .via_pb_ctl_out_in(stb_ctl), .via_irq_n_in(virq_n), .ser_irq_n_in(airq_n),
    .per_pa_drv_in(ppa), .per_pb_drv_in(ppb), .per_pa_ctl_out_in(rts_ctl),
    .per_pb_ctl_out_in(dtr_ctl), .bus_rdata_out(), .bus_rvalid_out(), .bus_claim_out(),
    .chip_sel_out(), .rom_addr_out(rom_a_big), .ram_addr_out(ram_a_big), .via_pa_out(),
    .via_pb_out(), .via_pa_ctl_in_out(), .via_pb_ctl_in_out(), .per_pb_out(),
    .scsi_data_out(), .scsi_data_oe_n_out(), .scsi_od_out(), .scsi_od_oe_n_out(),
    .scsi_sel_n_out(), .scsi_rst_n_out(), .scsi_ack_n_out(), .scsi_message_n_out(),
    .prn_strobe_n_out(), .rts_out(), .dtr_out(), .led_out());

  ebc_far_model far (.clk_in(clk_in), .env_in(env), .tgt_req_in(treq), .scsi_data_in(sd),
    .scsi_data_oe_n_in(sd_oe_n), .scsi_od_in(od), .scsi_od_oe_n_in(od_oe_n),
    .scsi_ack_n_in(ack_n), .pins_out(pins));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One host cycle; answers are settled when this returns
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    tick(1);
    hreq = '{addr: a, wdata: d, rd: !w, wr: w};
    tick(1);
    hreq.rd = 1'b0;
    hreq.wr = 1'b0;
  endtask

  task automatic t_decode();
    logic [15:0] a [7] = '{16'hd100, 16'hd11f, 16'hd140, 16'hd120, 16'hd150, 16'hd180,
      16'hd183};
    for (int i = 0; i < 7; i++) begin
      acc(a[i], 1'b0, 8'h00);
      chk(claim, i > 2);
      chk({cs.ser, cs.via, cs.per}, {i == 3, i == 4, i > 4});
      chk(cs.rs, a[i][3:0]);
    end
  endtask

  task automatic t_rom();
    for (int b = 0; b < 16; b++) begin
      acc(16'hd1c0 + 16'(b), 1'b1, 8'(b));
      tick(1);
      chk(led, b != 0);
      acc(16'hd800 + 16'(b * 129), 1'b0, 8'h00);
      chk(cs.rom, b != 0);
      if (b != 0) chk(rom_a, {1'b0, 4'(b), 11'(b * 129)});
    end
    // Writes into the ROM window must never select it
    acc(16'hd900, 1'b1, 8'h00);
    chk(cs.rom, 1'b0);
  endtask

  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      env.dcd = i[0];
      env.cts = i[1];
      env.dsr = !i[0];
      env.menu_n = i[1];
      env.shot_n = !i[1];
      virq_n = i[0];
      airq_n = !i[1];
      tick(6);
      acc(i[0] ? 16'hd1ff : 16'hd1c0, 1'b0, 8'h00);
      chk(rvalid, 1'b1);
      chk(rdata, {i[0], i[1], !i[0], 1'b0, i[1], !i[1], !i[0], i[1]});
      chk(btn_ctl, 1'b0);
    end
  endtask

  task automatic t_ram();
    ppa = 8'hff;
    ppb = 8'h06;
    acc(16'hd6a5, 1'b0, 8'h00);
    chk(cs.ram, 1'b1);
    chk(ram_a, {1'b0, 2'b00, 6'h3f, 8'ha5});
    chk(ram_a_big, {1'b1, 8'hff, 8'ha5});
    chk(rom_a_big, {1'b1, 4'hf, 11'h6a5});
    chk(rom_a[15], 1'b0);
    chk(msg_n, 1'b0);
    acc(16'hd1c0, 1'b1, 8'h10);
    acc(16'hd6a5, 1'b0, 8'h00);
    chk(claim, 1'b0);
    chk(msg_n, 1'b1);
    acc(16'hd700, 1'b0, 8'h00);
    chk(claim, 1'b0);
  endtask

  task automatic t_scsi();
    vpa = 8'h3c;
    vdir = 8'h0f;
    vpb = 8'h01;
    tick(2);
    chk(sd, 8'hc3);
    chk(sd_oe_n, 1'b0);
    chk({sel_n, rst_n}, 2'b00);
    chk(od_oe_n, 4'b1101);
    vpb = 8'h0c;
    env.data = 8'h5a;
    env.busy = 1'b1;
    env.fault_n = 1'b0;
    tick(6);
    chk(sd_oe_n, 1'b1);
    chk(vpa_o, 8'ha5);
    chk(vpb_o[5:4], 2'b01);
    env.dip_n[0] = 1'b0;
    tick(6);
    chk(vpb_o[5], 1'b1);
  endtask

  task automatic t_hs();
    treq = 1'b1;
    tick(1);
    treq = 1'b0;
    tick(6);
    chk(req_ctl, 1'b0);
    ack_ctl = 1'b0;
    tick(2);
    chk(ack_n, 1'b0);
    ack_ctl = 1'b1;
    tick(6);
    chk({req_ctl, ack_n}, 2'b11);
  endtask

  task automatic t_stb();
    int n = 0;
    stb_ctl = 1'b0;
    tick(1);
    stb_ctl = 1'b1;
    while (stb_n === 1'b0 && n < 100) begin
      n++;
      tick(1);
    end
    chk(n, EBC_STB_CYC);
    if (n >= 100) stop_test();
  endtask

  task automatic t_per();
    env.mode_n = 1'b0;
    env.wp_n = 1'b1;
    env.dip_n = 7'h55;
    env.menu_n = 1'b1;
    env.shot_n = 1'b1;
    rts_ctl = 1'b1;
    tick(6);
    chk(ppb_o, 8'haa);
    chk({rts, dtr}, 2'b10);
    chk(btn_ctl, 1'b1);
    rts_ctl = 1'b0;
    dtr_ctl = 1'b1;
    tick(2);
    chk({rts, dtr}, 2'b01);
  endtask

  initial begin
    tick(6);
    rst_n_in = 1'b1;
    t_decode();
    $display("decode done");
    t_rom();
    $display("rom done");
    t_status();
    $display("status done");
    t_ram();
    $display("ram done");
    t_scsi();
    $display("scsi done");
    t_hs();
    $display("handshake done");
    t_stb();
    $display("strobe done");
    t_per();
    $display("peripheral done");
    stop_test();
  end
endmodule // expansion_io_card_glue_tb
